// *** inc/bxcs_pkg.sv ***
// Shared constants of the biphase transceiver control and status bank
package bxcs_pkg;

  // ==========================================================
  // Register selects (index on reg_sel)
  localparam logic [3:0] SEL_MODE   = 4'h0;
  localparam logic [3:0] SEL_DATA   = 4'h1;
  localparam logic [3:0] SEL_CMD    = 4'h2;
  localparam logic [3:0] SEL_AUX    = 4'h3;
  localparam logic [3:0] SEL_FILL   = 4'h4;
  localparam logic [3:0] SEL_STATUS = 4'h5;
  localparam logic [3:0] SEL_FLAGS  = 4'h6;
  localparam logic [3:0] SEL_ERR    = 4'h7;
  localparam logic [3:0] SEL_DCFG   = 4'h8;

  // ==========================================================
  // Field positions
  localparam int MODE_SRST = 7;
  localparam int MODE_LOOP = 6;
  localparam int MODE_REPEAT_ENABLE = 5;
  localparam int MODE_RIN  = 4;
  localparam int MODE_TIN  = 3;
  localparam int CMD_RLQ   = 7;
  localparam int CMD_SEC   = 6;
  localparam int CMD_SLR   = 5;
  localparam int CMD_ATA   = 4;
  localparam int CMD_OWP   = 3;
  localparam int FLG_LTA   = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMD_RST  = 8'h80;
  localparam logic [7:0] AUX_RST  = 8'h00;
  localparam logic [7:0] FILL_RST = 8'h00;
  localparam logic [1:0] TCS_RST  = 2'h2;

  // ==========================================================
  // Protocol and clock codes
  localparam logic [2:0] PS_3270 = 3'h0;
  localparam logic [1:0] TCS_OSC  = 2'h0;
  localparam logic [1:0] TCS_HALF = 2'h1;
  localparam logic [1:0] TCS_QTR  = 2'h2;

  // ==========================================================
  // Counts and times
  localparam logic [4:0] LA_IDLE_TICKS = 5'h10;
  localparam logic [1:0] QUIESCE_SHORT = 2'h2;
  localparam logic [1:0] QUIESCE_LONG  = 2'h3;
  localparam logic [1:0] RX_DEPTH      = 2'h3;
  localparam int         HOLD_STEP_NS  = 500;
  localparam int         XCLK_REF_MHZ  = 8;
  localparam logic [8:0] HOLD_STEP_TICKS = 9'(HOLD_STEP_NS * XCLK_REF_MHZ / 1000);

endpackage

// *** design/bxcs_fifo.sv ***
// Parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module bxcs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  wire do_push = in_valid & in_ready;
  wire do_pop  = out_valid & out_ready;

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge mclk)
  begin
    if (do_push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= ptr_inc(wr_ptr);
      if (do_pop)
        rd_ptr <= ptr_inc(rd_ptr);
      if (do_push & ~do_pop)
        count <= count + CW'(1);
      else if (do_pop & ~do_push)
        count <= count - CW'(1);
    end
  end

endmodule // bxcs_fifo

`default_nettype wire

// *** design/bxcs_ctrl_status.sv ***
// Control and status register bank of the biphase serial transceiver
`timescale 1ns/1ps
`default_nettype none

module bxcs_ctrl_status #(
  parameter int TX_DEPTH = 8
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        data_in_pin,
  input  wire logic        analog_cmp_in,
  input  wire logic        ext_xcvr_clock,
  output logic             tx_active_out,
  input  wire logic        tx_active_out_core,
  input  wire logic        tx_serial,
  output logic             tx_word_valid,
  input  wire logic        tx_word_ready,
  output logic      [11:0] tx_word,
  input  wire logic        rx_word_valid,
  input  wire logic [10:0] rx_word,
  input  wire logic        rx_start,
  input  wire logic        rx_eom,
  input  wire logic        rx_err_ending,
  input  wire logic        rx_err_midbit,
  input  wire logic        rx_err_parity,
  input  wire logic        rx_byte_par_err,
  input  wire logic        rx_dec_poll,
  input  wire logic        rx_dec_ack,
  input  wire logic        rx_dec_autoresp,
  input  wire logic        rx_dec_sta111,
  output logic             rx_serial_in,
  output logic             rx_enable,
  output logic             xcvr_reset,
  output logic             xcvr_clock_tick,
  output logic      [2:0]  protocol_sel,
  output logic             rx_invert,
  output logic             tx_invert,
  output logic             advance_tx_active,
  output logic      [1:0]  quiesce_pulses,
  output logic      [8:0]  tx_hold_ticks,
  output logic      [7:0]  station_addr,
  output logic      [7:0]  fill_extra
);

  // ==========================================================
  // Control registers
  logic [7:0] transceiver_mode;
  logic [7:0] transceiver_command;
  logic [7:0] auxiliary_transceiver;
  logic [7:0] fill_bit_count;
  logic [1:0] xcvr_clock_sel;

  // ==========================================================
  // Access decode
  wire wr_mode  = reg_wr & (reg_sel == bxcs_pkg::SEL_MODE);
  wire wr_data  = reg_wr & (reg_sel == bxcs_pkg::SEL_DATA);
  wire wr_cmd   = reg_wr & (reg_sel == bxcs_pkg::SEL_CMD);
  wire wr_aux   = reg_wr & (reg_sel == bxcs_pkg::SEL_AUX);
  wire wr_fill  = reg_wr & (reg_sel == bxcs_pkg::SEL_FILL);
  wire wr_flags = reg_wr & (reg_sel == bxcs_pkg::SEL_FLAGS);
  wire wr_dcfg  = reg_wr & (reg_sel == bxcs_pkg::SEL_DCFG);
  wire rd_data  = reg_rd & (reg_sel == bxcs_pkg::SEL_DATA);
  wire rd_err   = reg_rd & (reg_sel == bxcs_pkg::SEL_ERR);

  wire soft_rst = transceiver_mode[bxcs_pkg::MODE_SRST];
  wire loop_on  = transceiver_mode[bxcs_pkg::MODE_LOOP];
  wire repeat_enable = transceiver_mode[bxcs_pkg::MODE_REPEAT_ENABLE];
  wire line_input_sel = transceiver_command[bxcs_pkg::CMD_SLR];
  wire is_3270 = (protocol_sel == bxcs_pkg::PS_3270);
  wire is_5250 = (protocol_sel[2:1] == 2'h2);
  wire is_coax = ~protocol_sel[2];

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      transceiver_mode      <= bxcs_pkg::MODE_RST;
      transceiver_command   <= bxcs_pkg::CMD_RST;
      auxiliary_transceiver <= bxcs_pkg::AUX_RST;
      fill_bit_count        <= bxcs_pkg::FILL_RST;
      xcvr_clock_sel        <= bxcs_pkg::TCS_RST;
    end
    else
    begin
      if (wr_mode)
        transceiver_mode <= reg_wdata;
      if (wr_cmd)
        transceiver_command <= reg_wdata;
      if (wr_aux)
        auxiliary_transceiver <= reg_wdata;
      if (wr_fill)
        fill_bit_count <= reg_wdata;
      if (wr_dcfg)
        xcvr_clock_sel <= reg_wdata[6:5];
    end
  end

  // ==========================================================
  // Control outputs
  // protocol to both directions
  assign protocol_sel = transceiver_mode[2:0];
  assign rx_invert    = transceiver_mode[bxcs_pkg::MODE_RIN];
  assign tx_invert    = transceiver_mode[bxcs_pkg::MODE_TIN];
  assign xcvr_reset   = sys_rst | soft_rst;
  assign tx_active_out = tx_active_out_core & ~loop_on;
  assign advance_tx_active = transceiver_command[bxcs_pkg::CMD_ATA];
  assign quiesce_pulses = transceiver_command[bxcs_pkg::CMD_RLQ] ?
                          bxcs_pkg::QUIESCE_LONG : bxcs_pkg::QUIESCE_SHORT;
  assign tx_hold_ticks = is_5250 ?
                         9'(auxiliary_transceiver[7:3]) * bxcs_pkg::HOLD_STEP_TICKS :
                         9'h000;
  assign station_addr = auxiliary_transceiver;
  assign fill_extra = ~fill_bit_count;
  assign rx_enable = repeat_enable | ~tx_active_out_core;

  // ==========================================================
  // Pin synchronisers: data, comparator, external clock
  // Three stages; a level is taken only once stages two and three agree
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_lvl;
  wire  [2:0] pin_raw = {ext_xcvr_clock, analog_cmp_in, data_in_pin};
  wire  [2:0] next_pin_lvl = (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_s1  <= 3'h0;
      pin_s2  <= 3'h0;
      pin_s3  <= 3'h0;
      pin_lvl <= 3'h0;
    end
    else
    begin
      pin_s1  <= pin_raw;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  // ==========================================================
  // Transceiver clock tick
  // The oscillator is mclk itself, so the selection is a tick, not a clock
  logic [1:0] div_cnt;
  logic       ext_prev;
  wire        ext_rise = pin_lvl[2] & ~ext_prev;

  assign xcvr_clock_tick =
    (xcvr_clock_sel == bxcs_pkg::TCS_OSC)  ? 1'b1 :
    (xcvr_clock_sel == bxcs_pkg::TCS_HALF) ? div_cnt[0] :
    (xcvr_clock_sel == bxcs_pkg::TCS_QTR)  ? (div_cnt == 2'h3) :
    ext_rise;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt  <= 2'h0;
      ext_prev <= 1'b0;
    end
    else
    begin
      div_cnt  <= div_cnt + 2'h1;
      ext_prev <= pin_lvl[2];
    end
  end

  // ==========================================================
  // Receiver input and line activity
  // line input choice
  wire line_raw = line_input_sel ? pin_lvl[1] : pin_lvl[0];
  assign rx_serial_in = loop_on ? tx_serial : (line_raw ^ rx_invert);

  logic       rx_prev;
  logic       line_activity;
  logic [4:0] idle_ticks;
  wire        rx_edge = rx_serial_in ^ rx_prev;
  wire        idle_done = xcvr_clock_tick &
                          (idle_ticks == bxcs_pkg::LA_IDLE_TICKS - 5'h1);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_prev       <= 1'b0;
      line_activity <= 1'b0;
      idle_ticks    <= 5'h00;
    end
    else
    begin
      rx_prev <= rx_serial_in;
      // set on edge, clear after idle
      if (rx_edge)
      begin
        line_activity <= 1'b1;
        idle_ticks    <= 5'h00;
      end
      else if (line_activity & xcvr_clock_tick)
      begin
        idle_ticks <= idle_ticks + 5'h01;
        if (idle_done)
          line_activity <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Transmit FIFO
  logic tx_in_ready;
  wire  tx_fifo_full  = ~tx_in_ready;
  wire  tx_fifo_empty = ~tx_word_valid;
  // push parity, frame bits and byte
  wire [11:0] tx_push_word = {transceiver_command[bxcs_pkg::CMD_OWP],
                              transceiver_command[2:0], reg_wdata};

  // writes while full are dropped by the FIFO
  bxcs_fifo #(
    .WIDTH (12),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (soft_rst),
    .in_valid  (wr_data & ~soft_rst),
    .in_ready  (tx_in_ready),
    .in_data   (tx_push_word),
    .out_valid (tx_word_valid),
    .out_ready (tx_word_ready),
    .out_data  (tx_word)
  );

  // ==========================================================
  // Receive FIFO, three words
  logic [10:0] rx_mem [0:2];
  logic [1:0]  rx_wp;
  logic [1:0]  rx_rp;
  logic [1:0]  rx_cnt;

  function automatic logic [1:0] rx_inc(input logic [1:0] p);
    rx_inc = (p == bxcs_pkg::RX_DEPTH - 2'h1) ? 2'h0 : p + 2'h1;
  endfunction

  wire rx_pop  = rd_data & (rx_cnt != 2'h0);
  wire rx_room = (rx_cnt != bxcs_pkg::RX_DEPTH) | rx_pop;
  wire rx_push = rx_word_valid & rx_room & ~soft_rst;
  wire rx_fifo_full = (rx_cnt == bxcs_pkg::RX_DEPTH);
  // Empty FIFO reads as zero so no unwritten word reaches the bus
  wire [10:0] rx_top = (rx_cnt != 2'h0) ? rx_mem[rx_rp] : 11'h000;

  always_ff @(posedge mclk)
  begin
    if (rx_push)
      rx_mem[rx_wp] <= rx_word;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_wp  <= 2'h0;
      rx_rp  <= 2'h0;
      rx_cnt <= 2'h0;
    end
    else if (soft_rst)
    begin
      rx_wp  <= 2'h0;
      rx_rp  <= 2'h0;
      rx_cnt <= 2'h0;
    end
    else
    begin
      if (rx_push)
        rx_wp <= rx_inc(rx_wp);
      if (rx_pop)
        rx_rp <= rx_inc(rx_rp);
      if (rx_push & ~rx_pop)
        rx_cnt <= rx_cnt + 2'h1;
      else if (rx_pop & ~rx_push)
        rx_cnt <= rx_cnt - 2'h1;
    end
  end

  // ==========================================================
  // Error events
  logic [4:0] err_code;
  logic       rx_busy_flag;
  // overrun and receiver killed by transmit
  wire ovf_ev  = rx_word_valid & ~rx_room;
  wire rx_killed_by_tx_ev = wr_data & rx_busy_flag & ~repeat_enable;
  wire [4:0] err_ev = {ovf_ev, rx_err_parity, rx_err_ending,
                       rx_err_midbit, rx_killed_by_tx_ev};
  wire any_err = |err_ev;

  // ==========================================================
  // Receive status flags
  logic rx_data_valid;
  logic rx_fault_flag;
  logic turnaround_flag;
  logic parity_or_msg_end;
  logic auto_response_flag;
  logic poll_ack_flag;
  logic poll_flag;
  wire  dav_now = rx_data_valid | rx_push;
  wire  lta_clr = wr_data | (wr_flags & reg_wdata[bxcs_pkg::FLG_LTA]);
  wire  parity_or_msg_end_set = (is_coax & rx_byte_par_err) |
                   (is_5250 & rx_dec_sta111 & dav_now);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      err_code           <= 5'h00;
      rx_busy_flag       <= 1'b0;
      rx_data_valid      <= 1'b0;
      rx_fault_flag      <= 1'b0;
      turnaround_flag    <= 1'b0;
      parity_or_msg_end  <= 1'b0;
      auto_response_flag <= 1'b0;
      poll_ack_flag      <= 1'b0;
      poll_flag          <= 1'b0;
    end
    else if (soft_rst)
    begin
      err_code           <= 5'h00;
      rx_busy_flag       <= 1'b0;
      rx_data_valid      <= 1'b0;
      rx_fault_flag      <= 1'b0;
      turnaround_flag    <= 1'b0;
      parity_or_msg_end  <= 1'b0;
      auto_response_flag <= 1'b0;
      poll_ack_flag      <= 1'b0;
      poll_flag          <= 1'b0;
    end
    else
    begin
      err_code <= (rd_err ? 5'h00 : err_code) | err_ev;
      rx_fault_flag <= any_err | (rx_fault_flag & ~rd_err);
      // start sets, end or error clears
      rx_busy_flag <= (rx_start & rx_enable) |
                      (rx_busy_flag & ~rx_eom & ~any_err);
      if (rx_push)
        rx_data_valid <= 1'b1;
      else if (any_err)
        rx_data_valid <= 1'b0;
      else if (rx_pop)
        rx_data_valid <= (rx_cnt > 2'h1);
      turnaround_flag <= rx_eom | (turnaround_flag & ~lta_clr);
      parity_or_msg_end <= parity_or_msg_end_set | (parity_or_msg_end & ~rd_data);
      poll_flag <= (is_3270 & rx_dec_poll & dav_now) |
                   (poll_flag & ~rd_data);
      poll_ack_flag <= (is_3270 & rx_dec_ack & dav_now) |
                       (poll_ack_flag & ~rd_data);
      auto_response_flag <= (is_3270 & rx_dec_autoresp & dav_now) |
                            (auto_response_flag & ~rd_data);
    end
  end

  // ==========================================================
  // Read path
  // upper bits of top word in status
  wire [7:0] status_rd = {tx_fifo_full, tx_active_out_core, rx_fault_flag,
                          rx_busy_flag, rx_data_valid, rx_top[10:8]};
  wire [7:0] flags_rd = {tx_fifo_empty, rx_fifo_full, line_activity,
                         turnaround_flag, parity_or_msg_end,
                         auto_response_flag, poll_ack_flag, poll_flag};
  wire [7:0] rd_mux =
    (reg_sel == bxcs_pkg::SEL_MODE)   ? transceiver_mode :
    (reg_sel == bxcs_pkg::SEL_DATA)   ? rx_top[7:0] :
    (reg_sel == bxcs_pkg::SEL_CMD)    ? transceiver_command :
    (reg_sel == bxcs_pkg::SEL_AUX)    ? auxiliary_transceiver :
    (reg_sel == bxcs_pkg::SEL_FILL)   ? fill_bit_count :
    (reg_sel == bxcs_pkg::SEL_STATUS) ? status_rd :
    (reg_sel == bxcs_pkg::SEL_FLAGS)  ? flags_rd :
    (reg_sel == bxcs_pkg::SEL_ERR)    ? {3'h0, err_code} :
    (reg_sel == bxcs_pkg::SEL_DCFG)   ? {1'b0, xcvr_clock_sel, 5'h00} :
    8'h00;

  // Read data is held until the next read so a slow core may sample late
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

endmodule // bxcs_ctrl_status

`default_nettype wire

// *** verif/bxcs_ctrl_status_monitor.sv ***
// Port checker of the transceiver control and status bank
`timescale 1ns/1ps
`default_nettype none
module bxcs_monitor (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [3:0]  reg_sel,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        tx_active_out,
  input wire logic        tx_active_out_core,
  input wire logic        rx_enable,
  input wire logic        xcvr_reset,
  input wire logic        tx_word_valid,
  input wire logic [11:0] tx_word,
  input wire logic [2:0]  protocol_sel,
  input wire logic        advance_tx_active,
  input wire logic [1:0]  quiesce_pulses,
  input wire logic [8:0]  tx_hold_ticks,
  input wire logic [7:0]  fill_extra
);
  // ==========================================================
  // Write decodes
  wire logic wr_mode = reg_wr && reg_sel == bxcs_pkg::SEL_MODE;
  wire logic wr_cmd  = reg_wr && reg_sel == bxcs_pkg::SEL_CMD;
  wire logic wr_aux  = reg_wr && reg_sel == bxcs_pkg::SEL_AUX;
  wire logic wr_fill = reg_wr && reg_sel == bxcs_pkg::SEL_FILL;
  wire logic wr_data = reg_wr && reg_sel == bxcs_pkg::SEL_DATA;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Properties
  loop_gate_a: assert property (tx_active_out |-> tx_active_out_core)
    else $error("activity pin high without core activity");
  loop_mask_a: assert property (wr_mode && reg_wdata[6] |=> !tx_active_out)
    else $error("activity pin not masked in loopback");
  rx_gate_a: assert property (!tx_active_out_core |-> rx_enable)
    else $error("receiver off while transmitter idle");
  xrst_hold_a: assert property (disable iff (1'b0) sys_rst |-> xcvr_reset)
    else $error("transceiver out of reset during chip reset");
  proto_sel_a: assert property (wr_mode |=> protocol_sel == $past(reg_wdata[2:0]))
    else $error("protocol select not taken");
  fill_inv_a: assert property (wr_fill |=> fill_extra == ~$past(reg_wdata))
    else $error("fill count not inverted");
  quiesce_cnt_a: assert property (wr_cmd |=> quiesce_pulses ==
    ($past(reg_wdata[7]) ? bxcs_pkg::QUIESCE_LONG : bxcs_pkg::QUIESCE_SHORT))
    else $error("quiesce count wrong");
  advance_bit_a: assert property (wr_cmd |=> advance_tx_active == $past(reg_wdata[4]))
    else $error("advance option not taken");
  hold_time_a: assert property (wr_aux && protocol_sel[2:1] == 2'h2 |=>
    tx_hold_ticks == {2'h0, $past(reg_wdata[7:3]), 2'h0})
    else $error("hold time wrong");
  tx_push_a: assert property (wr_data && !tx_word_valid && !xcvr_reset |=>
    tx_word_valid && tx_word[7:0] == $past(reg_wdata))
    else $error("data write not pushed");
  cover property (wr_data && !tx_word_valid);
  cover property (wr_aux && protocol_sel[2:1] == 2'h2);
  cover property (tx_active_out_core && !tx_active_out);
endmodule // bxcs_monitor
bind bxcs_ctrl_status bxcs_monitor u_mon (.mclk, .sys_rst, .reg_sel, .reg_wr, .reg_wdata,
  .tx_active_out, .tx_active_out_core, .rx_enable, .xcvr_reset, .tx_word_valid, .tx_word,
  .protocol_sel, .advance_tx_active, .quiesce_pulses, .tx_hold_ticks, .fill_extra);
`default_nettype wire

// *** verif/bxcs_core_model.sv ***
// Model of the serial core that drains transmit words and delivers receive words
`timescale 1ns/1ps
`default_nettype none
module bxcs_core_model (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire logic        send,
  input  wire logic [10:0] send_word,
  input  wire logic        tx_word_valid,
  input  wire logic [11:0] tx_word,
  output logic             tx_word_ready,
  output logic             rx_word_valid,
  output logic      [10:0] rx_word,
  output logic      [11:0] last_tx
);
  assign tx_word_ready = !stall;
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      rx_word_valid <= 1'b0;
      rx_word       <= 11'h000;
    end
    else
    begin
      rx_word_valid <= send;
      // Word bus changes every idle cycle so a stale word is never mistaken
      rx_word       <= send ? send_word : ~rx_word;
      if (tx_word_valid && tx_word_ready)
        last_tx <= tx_word;
    end
endmodule // bxcs_core_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench of the transceiver control and status bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %0h want %0h", $time, a, e); end end
module tb_top;
  logic mclk, sys_rst, reg_wr, reg_rd, stall, send, data_in_pin, analog_cmp_in;
  logic ext_xcvr_clock, tx_active_out_core, tx_serial, tx_active_out, tx_word_valid;
  logic tx_word_ready, rx_word_valid, rx_serial_in, rx_enable, xcvr_reset;
  logic xcvr_clock_tick, rx_invert, tx_invert, advance_tx_active, ext_div;
  logic [3:0]  reg_sel;
  logic [7:0]  reg_wdata, reg_rdata, v, station_addr, fill_extra;
  logic [9:0]  ev;
  logic [10:0] send_word, rx_word;
  logic [11:0] tx_word, last_tx;
  logic [2:0]  protocol_sel;
  logic [1:0]  quiesce_pulses;
  logic [8:0]  tx_hold_ticks;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n;
  bxcs_ctrl_status dut (.mclk, .sys_rst, .reg_sel, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .data_in_pin, .analog_cmp_in, .ext_xcvr_clock, .tx_active_out,
    .tx_active_out_core, .tx_serial, .tx_word_valid, .tx_word_ready, .tx_word, .rx_word_valid,
    .rx_word, .rx_start(ev[0]), .rx_eom(ev[1]), .rx_err_midbit(ev[2]),
    .rx_err_ending(ev[3]), .rx_err_parity(ev[4]), .rx_dec_poll(ev[5]), .rx_dec_ack(ev[6]),
    .rx_dec_autoresp(ev[7]), .rx_byte_par_err(ev[8]), .rx_dec_sta111(ev[9]),
    .rx_serial_in, .rx_enable, .xcvr_reset, .xcvr_clock_tick, .protocol_sel, .rx_invert,
    .tx_invert, .advance_tx_active, .quiesce_pulses, .tx_hold_ticks, .station_addr,
    .fill_extra);
  bxcs_core_model u_core (.mclk, .sys_rst, .stall, .send, .send_word, .tx_word_valid,
    .tx_word, .tx_word_ready, .rx_word_valid, .rx_word, .last_tx);
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(posedge mclk);
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [3:0] s, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    reg_sel <= s;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    `CHK(v & m, e)
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    ev <= 10'(1) << i;
    @(posedge mclk);
    ev <= '0;
    #1;
  endtask
  task automatic push(input logic [10:0] w);
    @(posedge mclk);
    send <= 1'b1;
    send_word <= w;
    @(posedge mclk);
    send <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rc(4'h0, 8'hFF, 8'h00);
    rc(4'h2, 8'hFF, 8'h80);
    rc(4'h8, 8'h60, 8'h40);
    rc(4'h6, 8'hFF, 8'h80);
    rc(4'h5, 8'hFF, 8'h00);
    rc(4'h7, 8'hFF, 8'h00);
    rc(4'hF, 8'hFF, 8'h00);
    `CHK(protocol_sel, 3'h0)
    $display("test reset done");
  endtask
  task automatic t_cfg();
    int exp[4] = '{8, 4, 2, 2};
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h8, 8'(c << 5));
      repeat (6) @(posedge mclk);
      n = 0;
      repeat (8)
      begin
        @(posedge mclk);
        #1 n += int'(xcvr_clock_tick === 1'b1);
      end
      `CHK(n, exp[c])
    end
    wr(4'h8, 8'h40);
    for (int p = 7; p >= 0; p--)
    begin
      wr(4'h0, 8'(p));
      `CHK(protocol_sel, 3'(p))
    end
    wr(4'h0, 8'h04);
    wr(4'h3, 8'hF8);
    `CHK(tx_hold_ticks, 9'h07C)
    `CHK(station_addr, 8'hF8)
    wr(4'h0, 8'h00);
    `CHK(tx_hold_ticks, 9'h000)
    wr(4'h4, 8'h3C);
    `CHK(fill_extra, 8'hC3)
    wr(4'h2, 8'h10);
    `CHK(quiesce_pulses, 2'h2)
    `CHK(advance_tx_active, 1'b1)
    $display("test config done");
  endtask
  task automatic t_tx();
    @(posedge mclk) stall <= 1'b1;
    wr(4'h2, 8'h8D);
    wr(4'h1, 8'hA5);
    `CHK(tx_word, 12'hDA5)
    for (int i = 1; i < 8; i++)
      wr(4'h1, 8'(i));
    rc(4'h5, 8'h80, 8'h80);
    rc(4'h6, 8'h80, 8'h00);
    @(posedge mclk) stall <= 1'b0;
    repeat (12) @(posedge mclk);
    `CHK(last_tx, 12'hD07)
    rc(4'h6, 8'h80, 8'h80);
    $display("test transmit done");
  endtask
  task automatic t_rx();
    push(11'h5C1);
    push(11'h2B2);
    push(11'h0C3);
    rc(4'h5, 8'h0F, 8'h0D);
    rc(4'h6, 8'h40, 8'h40);
    push(11'h7FF);
    rc(4'h5, 8'h20, 8'h20);
    rc(4'h7, 8'hFF, 8'h10);
    rc(4'h5, 8'h20, 8'h00);
    rc(4'h1, 8'hFF, 8'hC1);
    rc(4'h6, 8'h40, 8'h00);
    rc(4'h1, 8'hFF, 8'hB2);
    rc(4'h1, 8'hFF, 8'hC3);
    rc(4'h5, 8'h08, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      pulse(2 + i);
      rc(4'h7, 8'hFF, 8'h02 << i);
    end
    $display("test receive done");
  endtask
  task automatic t_flags();
    pulse(0);
    rc(4'h5, 8'h10, 8'h10);
    pulse(1);
    rc(4'h5, 8'h10, 8'h00);
    rc(4'h6, 8'h10, 8'h10);
    wr(4'h6, 8'h10);
    rc(4'h6, 8'h10, 8'h00);
    push(11'h001);
    for (int i = 5; i < 9; i++)
      pulse(i);
    rc(4'h6, 8'h0F, 8'h0F);
    rc(4'h1, 8'hFF, 8'h01);
    rc(4'h6, 8'h0F, 8'h00);
    wr(4'h0, 8'h04);
    push(11'h002);
    pulse(9);
    rc(4'h6, 8'h08, 8'h08);
    rc(4'h1, 8'hFF, 8'h02);
    $display("test flags done");
  endtask
  task automatic t_pins();
    @(posedge mclk);
    tx_active_out_core <= 1'b1;
    tx_serial <= 1'b1;
    data_in_pin <= 1'b1;
    wr(4'h0, 8'h40);
    `CHK(tx_active_out, 1'b0)
    `CHK(rx_serial_in, 1'b1)
    `CHK(rx_enable, 1'b0)
    wr(4'h0, 8'h20);
    `CHK(tx_active_out, 1'b1)
    `CHK(rx_enable, 1'b1)
    wr(4'h0, 8'h80);
    `CHK(xcvr_reset, 1'b1)
    wr(4'h0, 8'h18);
    `CHK(rx_serial_in, 1'b0)
    `CHK({rx_invert, tx_invert}, 2'h3)
    wr(4'h0, 8'h00);
    `CHK(rx_serial_in, 1'b1)
    wr(4'h2, 8'hA0);
    repeat (4) @(posedge mclk);
    `CHK(rx_serial_in, 1'b0)
    wr(4'h2, 8'h80);
    @(posedge mclk) data_in_pin <= 1'b0;
    rc(4'h6, 8'h20, 8'h20);
    repeat (90) @(posedge mclk);
    rc(4'h6, 8'h20, 8'h00);
    $display("test pins done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // Clock, stimulus and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // External clock at a quarter rate so the pin filter sees stable levels
  always @(posedge mclk) {ext_xcvr_clock, ext_div} <= {ext_xcvr_clock, ext_div} + 2'h1;
  initial
  begin
    {reg_wr, reg_rd, stall, send, tx_active_out_core, tx_serial, analog_cmp_in} = '0;
    {data_in_pin, ext_xcvr_clock, ext_div, ev, reg_sel, reg_wdata, send_word} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_cfg();
    t_tx();
    t_rx();
    t_flags();
    t_pins();
    test_done();
  end
  initial
  begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
